// [hdl/rtcsm_pkg.sv]
package rtcsm_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;  // override enable and mode bits
  localparam logic [7:0] ADDR_STATUS  = 8'h01;  // read-only state view
  localparam logic [7:0] ADDR_SECONDS = 8'h03;  // seconds_and_integrity
  localparam logic [7:0] ADDR_MINUTES = 8'h04;  // minutes_count

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int STOP_FLAG_BIT   = 7;  // seconds bit 7
  localparam int TENS_MSB        = 6;  // tens digit bits 6..4
  localparam int TENS_LSB        = 4;
  localparam int UNITS_MSB       = 3;  // units digit bits 3..0
  localparam int CTL_OVR_EN_BIT  = 0;  // control: override enable
  localparam int CTL_HOUR12_BIT  = 1;  // control: 1 selects 12-hour mode
  localparam int CTL_SQW_OFF_BIT = 2;  // control: 1 stops square wave
  localparam int CTL_BSW_OFF_BIT = 3;  // control: 1 disables battery switch-over
  localparam int CTL_BLD_OFF_BIT = 4;  // control: 1 disables battery-low detect
  localparam int CTL_PFD_OFF_BIT = 5;  // control: 1 disables power-fail detect
  localparam int STS_RESET_BIT   = 0;  // status: internal reset active
  localparam int STS_OVR_BIT     = 1;  // status: override mode active
  localparam int STS_STABLE_BIT  = 2;  // status: oscillator stable

  // ****************************************************************
  // reset values and digit limits
  // ****************************************************************
  localparam logic [7:0] CONTROL_RST   = 8'h00;  // 24 h, override off, all other functions on
  localparam logic       STOP_FLAG_RST = 1'b1;   // stop flag after power-on
  localparam logic [2:0] TENS_MAX      = 3'h5;   // tens digit 0..5
  localparam logic [3:0] UNITS_MAX     = 4'h9;   // units digit 0..9

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CORE_CLK_HZ    = 20_000_000;  // core clock rate
  localparam int unsigned OSC_STABLE_MS  = 200;         // least start-up time
  localparam int unsigned SQW_FREQ_HZ    = 32_768;      // square wave rate
  localparam int unsigned LINK_PERIOD_NS = 12;          // pin sampling period
  localparam int unsigned OVR_MIN_NS     = 100;         // least pin phase width
  localparam int unsigned STABLE_CYC_DEF = (CORE_CLK_HZ / 1000) * OSC_STABLE_MS;
  localparam int unsigned SEC_CYC_DEF    = CORE_CLK_HZ;
  localparam int unsigned SQW_HALF_CYC   = CORE_CLK_HZ / (2 * SQW_FREQ_HZ);
  localparam int unsigned OVR_MIN_CYC    = (OVR_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // ****************************************************************
  // override pin sequence, {sda_ce, scl} per phase
  // ****************************************************************
  localparam int         OVR_STEPS = 4;
  localparam logic [7:0] OVR_PATTERN = 8'hB1;  // phases 01, 00, 11, 10 (phase 0 in low bits)

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic sda_ce;  // serial data / chip enable pin
    logic scl;     // serial clock pin
  } rtcsm_pins_t;

  typedef struct packed {
    logic hour12;       // 12-hour mode selected
    logic bsw_en;       // battery switch-over enabled
    logic batlow_en;    // battery-low detection enabled
    logic pfail_en;     // extra power-fail detection enabled
  } rtcsm_mode_t;

endpackage : rtcsm_pkg

// [hdl/rtcsm_core.sv]
`timescale 1ns/1ps

module rtcsm_core #(
  parameter int unsigned SEC_CYC    = rtcsm_pkg::SEC_CYC_DEF,     // core cycles per second
  parameter int unsigned STABLE_CYC = rtcsm_pkg::STABLE_CYC_DEF   // oscillator settle cycles
) (
  input  wire logic                 core_clk,            // core clock, 20 MHz
  input  wire logic                 rst,                 // power-on reset, sync, high
  input  wire logic                 link_clk,            // pin sampling clock
  input  wire rtcsm_pkg::rtcsm_pins_t if_pins,           // serial interface pins
  input  wire logic                 osc_running,         // oscillator detector, async
  input  wire logic                 supply_low,          // supply below low threshold, async
  input  wire logic [7:0]           addr,                // register address
  input  wire logic [7:0]           wr_data,             // write data
  input  wire logic                 wr_en,               // write strobe
  input  wire logic                 rd_en,               // read strobe
  output logic [7:0]                rd_data,             // read data, cycle after strobe
  output logic                      chip_in_reset,       // internal reset active
  output logic                      reset_override_mode, // override mode active
  output logic                      square_wave_out,     // 32.768 kHz clock output
  output logic                      hours_carry,         // one-cycle carry into hours
  output rtcsm_pkg::rtcsm_mode_t    mode_out             // mode bits to other blocks
);
  import rtcsm_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (SEC_CYC < 2) begin : g_bad_sec
    $error("SEC_CYC must be at least 2");
  end
  if (STABLE_CYC < 1) begin : g_bad_stable
    $error("STABLE_CYC must be at least 1");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0]  osc_sync;          // oscillator detector synchroniser
  logic [1:0]  low_sync;          // low-supply synchroniser
  logic        osc_ok;            // oscillation present and supply fine
  logic [31:0] stable_cnt;        // settle counter
  logic        osc_stable;        // oscillator considered running
  logic        osc_stable_d;      // previous stable state
  logic        int_reset;         // internal reset
  logic        stop_flag;         // clock integrity flag
  logic [7:0]  control;           // control register
  logic        ovr_enable;        // override enable bit
  logic [2:0]  ovr_evt_sync;      // event toggle sync plus history
  logic        ovr_event;         // sequence recognised, core pulse
  logic [31:0] sec_cnt;           // one-second prescaler
  logic        sec_tick;          // one-second pulse
  logic [2:0]  sec_tens;          // seconds tens digit
  logic [3:0]  sec_units;         // seconds units digit
  logic [2:0]  min_tens;          // minutes tens digit
  logic [3:0]  min_units;         // minutes units digit
  logic        wr_sec;            // write to seconds
  logic        wr_min;            // write to minutes
  logic        sec_wrap;          // seconds 59 -> 00
  logic        min_wrap;          // minutes 59 -> 00
  logic [15:0] sqw_cnt;           // square wave half-period counter
  logic        sqw_level;         // square wave level
  // link domain
  logic [1:0]  link_rst_sync;     // reset into link domain
  logic        link_rst;          // link-side reset
  logic [1:0]  arm_sync;          // override enable into link domain
  rtcsm_pins_t pin_meta;          // pin synchroniser, first stage
  rtcsm_pins_t pin_now;           // pins, synchronised
  rtcsm_pins_t pin_prev;          // pins, one cycle earlier
  logic [1:0]  ovr_step;          // current phase of sequence
  logic [7:0]  ovr_hold;          // cycles in current phase
  logic        ovr_toggle;        // event toggle to core domain

  // ****************************************************************
  // oscillator stop detection and internal reset
  // ****************************************************************
  // async detector inputs pass two flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_sync <= 2'h0;
      low_sync <= 2'h0;
    end else begin
      osc_sync <= {osc_sync[0], osc_running};
      low_sync <= {low_sync[0], supply_low};
    end
  end

  // low supply counts as stopped oscillation
  assign osc_ok = osc_sync[1] & ~low_sync[1];

  // settle timer; any stop restarts it
  always_ff @(posedge core_clk) begin
    if (rst || !osc_ok) begin
      stable_cnt <= 32'h0;
      osc_stable <= 1'b0;
    end else if (!osc_stable) begin
      if (stable_cnt == STABLE_CYC - 1) begin
        osc_stable <= 1'b1;
      end else begin
        stable_cnt <= stable_cnt + 32'h1;
      end
    end
  end

  // history of stable, to spot a stop after running
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_stable_d <= 1'b0;
    end else begin
      osc_stable_d <= osc_stable;
    end
  end

  // reset holds until stable unless overridden
  assign int_reset     = ~osc_stable & ~reset_override_mode;
  assign chip_in_reset = int_reset;

  // ****************************************************************
  // integrity flag
  // ****************************************************************
  // set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stop_flag <= STOP_FLAG_RST;
    end else if (int_reset) begin
      stop_flag <= 1'b1;
    end else if (wr_sec && !wr_data[STOP_FLAG_BIT]) begin
      stop_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // control register and mode
  // ****************************************************************
  // defaults only on power-on; internal reset keeps arming
  always_ff @(posedge core_clk) begin
    if (rst) begin
      control <= CONTROL_RST;
    end else if (wr_en && addr == ADDR_CONTROL) begin
      control <= {2'h0, wr_data[5:0]};
    end
  end

  assign ovr_enable         = control[CTL_OVR_EN_BIT];
  assign mode_out.hour12    = control[CTL_HOUR12_BIT];
  assign mode_out.bsw_en    = ~control[CTL_BSW_OFF_BIT];
  assign mode_out.batlow_en = ~control[CTL_BLD_OFF_BIT];
  assign mode_out.pfail_en  = ~control[CTL_PFD_OFF_BIT];

  // ****************************************************************
  // override mode
  // ****************************************************************
  // event toggle from link domain, two flops then edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovr_evt_sync <= 3'h0;
    end else begin
      ovr_evt_sync <= {ovr_evt_sync[1:0], ovr_toggle};
    end
  end

  assign ovr_event = ovr_evt_sync[2] ^ ovr_evt_sync[1];

  // entry needs enable; clearing enable leaves time untouched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_override_mode <= 1'b0;
    end else if (!ovr_enable) begin
      reset_override_mode <= 1'b0;
    end else if (ovr_event) begin
      reset_override_mode <= 1'b1;
    end else if (osc_stable_d && !osc_stable) begin
      reset_override_mode <= 1'b0;  // real stop ends override
    end
  end

  // ****************************************************************
  // one-second prescaler
  // ****************************************************************
  // held at zero while in internal reset
  always_ff @(posedge core_clk) begin
    if (rst || int_reset) begin
      sec_cnt <= 32'h0;
    end else if (sec_tick) begin
      sec_cnt <= 32'h0;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end

  assign sec_tick = (sec_cnt == SEC_CYC - 1);

  // ****************************************************************
  // time counters (not reset: kept across resets)
  // ****************************************************************
  assign wr_sec   = wr_en && addr == ADDR_SECONDS;
  assign wr_min   = wr_en && addr == ADDR_MINUTES;
  assign sec_wrap = sec_tick && sec_tens == TENS_MAX && sec_units == UNITS_MAX;
  assign min_wrap = sec_wrap && min_tens == TENS_MAX && min_units == UNITS_MAX;

  // seconds: write beats tick
  always_ff @(posedge core_clk) begin
    if (wr_sec) begin
      sec_tens  <= wr_data[TENS_MSB:TENS_LSB];
      sec_units <= wr_data[UNITS_MSB:0];
    end else if (sec_tick) begin
      if (sec_units == UNITS_MAX) begin
        sec_units <= 4'h0;
        sec_tens  <= (sec_tens == TENS_MAX) ? 3'h0 : sec_tens + 3'h1;
      end else begin
        sec_units <= sec_units + 4'h1;
      end
    end
  end

  // minutes: advance on seconds wrap
  always_ff @(posedge core_clk) begin
    if (wr_min) begin
      min_tens  <= wr_data[TENS_MSB:TENS_LSB];
      min_units <= wr_data[UNITS_MSB:0];
    end else if (sec_wrap) begin
      if (min_units == UNITS_MAX) begin
        min_units <= 4'h0;
        min_tens  <= (min_tens == TENS_MAX) ? 3'h0 : min_tens + 3'h1;
      end else begin
        min_units <= min_units + 4'h1;
      end
    end
  end

  // carry pulse to the hours counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hours_carry <= 1'b0;
    end else begin
      hours_carry <= min_wrap && !wr_min;
    end
  end

  // ****************************************************************
  // square wave output
  // ****************************************************************
  // free divider; low when disabled
  always_ff @(posedge core_clk) begin
    if (rst || control[CTL_SQW_OFF_BIT]) begin
      sqw_cnt   <= 16'h0;
      sqw_level <= 1'b0;
    end else if (sqw_cnt == 16'(SQW_HALF_CYC - 1)) begin
      sqw_cnt   <= 16'h0;
      sqw_level <= ~sqw_level;
    end else begin
      sqw_cnt <= sqw_cnt + 16'h1;
    end
  end

  assign square_wave_out = sqw_level;

  // ****************************************************************
  // register read port
  // ****************************************************************
  // data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        ADDR_CONTROL: rd_data <= control;
        ADDR_STATUS:  rd_data <= {5'h00, osc_stable, reset_override_mode, int_reset};
        ADDR_SECONDS: rd_data <= {stop_flag, sec_tens, sec_units};
        ADDR_MINUTES: rd_data <= {1'b0, min_tens, min_units};
        default:      rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ****************************************************************
  // link domain: pin sequence detector
  // ****************************************************************
  // reset and arming level carried over by two flops
  always_ff @(posedge link_clk) begin
    link_rst_sync <= {link_rst_sync[0], rst};
    arm_sync      <= {arm_sync[0], ovr_enable};
  end

  assign link_rst = link_rst_sync[1];

  // pins pass two flops, then one of history
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      pin_meta <= '0;
      pin_now  <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= if_pins;
      pin_now  <= pin_meta;
      pin_prev <= pin_now;
    end
  end

  // each phase held at least the least width, then next phase
  always_ff @(posedge link_clk) begin
    if (link_rst || !arm_sync[1]) begin
      ovr_step <= 2'h0;
      ovr_hold <= 8'h0;
    end else if (pin_now != pin_prev) begin
      ovr_hold <= 8'h0;
      if (ovr_step != 2'(OVR_STEPS - 1) && pin_prev == OVR_PATTERN[2*ovr_step +: 2]
          && ovr_hold >= 8'(OVR_MIN_CYC - 1)
          && pin_now == OVR_PATTERN[2*(ovr_step + 2'h1) +: 2]) begin
        ovr_step <= ovr_step + 2'h1;
      end else begin
        ovr_step <= 2'h0;
      end
    end else if (ovr_hold != 8'hFF) begin
      ovr_hold <= ovr_hold + 8'h1;
    end
  end

  // last phase held long enough: flip event toggle once
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ovr_toggle <= 1'b0;
    end else if (arm_sync[1] && ovr_step == 2'(OVR_STEPS - 1)
                 && pin_now == OVR_PATTERN[2*ovr_step +: 2]
                 && ovr_hold == 8'(OVR_MIN_CYC - 1)) begin
      ovr_toggle <= ~ovr_toggle;
    end
  end

endmodule : rtcsm_core

// [test/rtcsm_core_assertions.sv]
`timescale 1ns/1ps

// ****************************************************************
// port checker for the timekeeping core
// ****************************************************************
module rtcsm_core_assertions #(
  parameter int unsigned SEC_CYC    = 20,  // core cycles per second
  parameter int unsigned STABLE_CYC = 50   // oscillator settle cycles
) (
  input wire logic                   core_clk,            // core clock
  input wire logic                   rst,                 // power-on reset
  input wire logic                   link_clk,            // pin clock
  input wire rtcsm_pkg::rtcsm_pins_t if_pins,             // serial pins
  input wire logic                   osc_running,         // oscillator detector
  input wire logic                   supply_low,          // low supply
  input wire logic [7:0]             addr,                // register address
  input wire logic [7:0]             wr_data,             // write data
  input wire logic                   wr_en,               // write strobe
  input wire logic                   rd_en,               // read strobe
  input wire logic [7:0]             rd_data,             // read data
  input wire logic                   chip_in_reset,       // internal reset
  input wire logic                   reset_override_mode, // override active
  input wire logic                   square_wave_out,     // clock output
  input wire logic                   hours_carry,         // carry to hours
  input wire rtcsm_pkg::rtcsm_mode_t mode_out             // mode bits
);
  import rtcsm_pkg::*;
  logic [15:0] ok_cnt;  // run of good oscillator input

  // counts cycles of running oscillator at normal supply
  always_ff @(posedge core_clk) begin
    if (rst || !osc_running || supply_low) begin
      ok_cnt <= 16'h0000;
    end else if (ok_cnt != 16'hFFFF) begin
      ok_cnt <= ok_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_sec_rd;
    rd_en && addr == ADDR_SECONDS;
  endsequence
  sequence s_min_rd;
    rd_en && addr == ADDR_MINUTES;
  endsequence
  sequence s_reset_sec_rd;
    chip_in_reset ##1 (chip_in_reset && rd_en && addr == ADDR_SECONDS);
  endsequence

  AST_FLAG_IN_RESET: assert property (s_reset_sec_rd |=> rd_data[STOP_FLAG_BIT])
    else $error("stop flag clear while in reset");
  AST_SEC_DIGITS: assert property (s_sec_rd |=> rd_data[6:4] <= TENS_MAX && rd_data[3:0] <= UNITS_MAX)
    else $error("seconds digits out of range");
  AST_MIN_BIT7: assert property (s_min_rd |=> rd_data[7] == 1'b0)
    else $error("minutes bit 7 not zero");
  AST_OSC_STOP: assert property ((!osc_running && !reset_override_mode)[*4] |-> chip_in_reset)
    else $error("no reset with oscillator stopped");
  AST_LOW_SUPPLY: assert property ((supply_low && !reset_override_mode)[*4] |-> chip_in_reset)
    else $error("no reset at low supply");
  AST_SETTLE: assert property ($fell(chip_in_reset) && !reset_override_mode |-> ok_cnt >= STABLE_CYC)
    else $error("reset left before oscillator settled");
  AST_POR_MODE: assert property ($fell(rst) |-> mode_out == 4'h7 && chip_in_reset)
    else $error("wrong mode after power-on");
  AST_OVR_CLEAR: assert property (wr_en && addr == ADDR_CONTROL && !wr_data[0] |=> ##1 !reset_override_mode)
    else $error("override kept after enable cleared");
  AST_OVR_RELEASE: assert property (reset_override_mode |-> !chip_in_reset)
    else $error("reset held in override mode");
  AST_CARRY_PULSE: assert property (hours_carry |=> !hours_carry)
    else $error("hours carry longer than one cycle");
  AST_SQW_HALF: assert property ($changed(square_wave_out) |=> $stable(square_wave_out) [*8])
    else $error("clock output toggles too fast");
endmodule : rtcsm_core_assertions

bind rtcsm_core rtcsm_core_assertions #(.SEC_CYC(SEC_CYC), .STABLE_CYC(STABLE_CYC)) u_chk (
  .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .if_pins(if_pins),
  .osc_running(osc_running), .supply_low(supply_low), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .chip_in_reset(chip_in_reset),
  .reset_override_mode(reset_override_mode), .square_wave_out(square_wave_out),
  .hours_carry(hours_carry), .mode_out(mode_out));

// [test/rtcsm_host_pins.sv]
`timescale 1ns/1ps

// ****************************************************************
// host pin driver for override entry
// ****************************************************************
module rtcsm_host_pins (
  input  wire logic              link_clk, // pin timing clock
  input  wire logic              go,       // play the sequence once
  output rtcsm_pkg::rtcsm_pins_t if_pins,  // serial pins
  output logic                   done      // sequence finished
);
  import rtcsm_pkg::*;
  localparam int         HOLD = 13;                                  // link cycles a phase, over 100 ns
  localparam logic [1:0] PHASE [4] = '{2'b01, 2'b00, 2'b11, 2'b10};  // entry order

  // plays one sequence per request, pins idle high between
  initial begin
    if_pins = 2'b11;
    done    = 1'b0;
    forever begin
      @(posedge link_clk iff go);
      for (int i = 0; i < 4; i++) begin
        if_pins <= PHASE[i];
        repeat (HOLD) @(posedge link_clk);
      end
      if_pins <= 2'b11;
      done    <= 1'b1;
      @(posedge link_clk iff !go);
      done    <= 1'b0;
    end
  end
endmodule : rtcsm_host_pins

// [test/test_rtcsm_core.sv]
`timescale 1ns/1ps

// ****************************************************************
// self-checking bench for the timekeeping core
// ****************************************************************
module test_rtcsm_core;
  import rtcsm_pkg::*;
  localparam int unsigned SECC = 20;  // short second
  localparam int unsigned STBC = 50;  // short settle time
  logic        core_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, osc_running = 1'b0, supply_low = 1'b0;
  logic [7:0]  addr = 8'h00, wr_data = 8'h00, rd_data, v;
  logic        wr_en = 1'b0, rd_en = 1'b0, go = 1'b0, done;
  logic        chip_in_reset, reset_override_mode, square_wave_out, hours_carry;
  rtcsm_pins_t if_pins;
  rtcsm_mode_t mode_out;
  int          errors = 0, checks = 0;

  always #25 core_clk = ~core_clk;
  initial #3 forever #6 link_clk = ~link_clk;  // unrelated phase

  rtcsm_core #(.SEC_CYC(SECC), .STABLE_CYC(STBC)) DUT (
    .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .if_pins(if_pins),
    .osc_running(osc_running), .supply_low(supply_low), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .chip_in_reset(chip_in_reset),
    .reset_override_mode(reset_override_mode), .square_wave_out(square_wave_out),
    .hours_carry(hours_carry), .mode_out(mode_out));
  rtcsm_host_pins u_host (.link_clk(link_clk), .go(go), .if_pins(if_pins), .done(done));

  task automatic conclude;
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk) d = rd_data;
  endtask : rd
  task automatic wait_rst(input logic lvl, input int n);  // bounded wait on internal reset
    repeat (n) if (chip_in_reset !== lvl) @(posedge core_clk) #1;
  endtask : wait_rst
  task automatic play_seq;  // one pin sequence through the host model
    go <= 1'b1;
    repeat (100) if (done !== 1'b1) @(posedge core_clk);
    go <= 1'b0;
    repeat (10) if (done !== 1'b0) @(posedge core_clk);
  endtask : play_seq

  task automatic t_power_on;
    chk_bit(chip_in_reset, 1'b1);
    chk_byte({4'h0, mode_out}, 8'h07);
    rd(ADDR_CONTROL, v); chk_byte(v, CONTROL_RST);
    wr(ADDR_SECONDS, 8'h58);
    wr(ADDR_MINUTES, 8'hD9);
    rd(ADDR_SECONDS, v); chk_byte(v, 8'hD8);
    rd(ADDR_MINUTES, v); chk_byte(v, 8'h59);
    rd(8'h02, v); chk_byte(v, 8'h00);
    rd(ADDR_STATUS, v); chk_byte(v, 8'h01);
    repeat (700) if (square_wave_out !== 1'b1) @(posedge core_clk) #1;
    chk_bit(square_wave_out, 1'b1);
  endtask : t_power_on

  task automatic t_override;
    wr(ADDR_CONTROL, 8'h01);
    play_seq();
    repeat (20) if (reset_override_mode !== 1'b1) @(posedge core_clk) #1;
    chk_bit(reset_override_mode, 1'b1);
    chk_bit(chip_in_reset, 1'b0);
    rd(ADDR_STATUS, v); chk_byte(v, 8'h02);
    wr(ADDR_CONTROL, 8'h00);
    @(posedge core_clk) #1 chk_bit(reset_override_mode, 1'b0);
    wait_rst(1'b1, 5); chk_bit(chip_in_reset, 1'b1);
    play_seq();
    repeat (20) @(posedge core_clk);
    chk_bit(reset_override_mode, 1'b0);
  endtask : t_override

  task automatic t_osc_start;
    int n;
    n = 0;
    @(posedge core_clk);
    osc_running <= 1'b1;
    while (chip_in_reset !== 1'b0 && n < 200) begin
      @(posedge core_clk) #1;
      n++;
    end
    chk_bit(n >= STBC, 1'b1);
    chk_bit(chip_in_reset, 1'b0);
    rd(ADDR_SECONDS, v); chk_bit(v[7], 1'b1);
    wr(ADDR_SECONDS, 8'h00);
    rd(ADDR_SECONDS, v); chk_byte(v, 8'h00);
  endtask : t_osc_start

  task automatic t_count;
    wr(ADDR_CONTROL, 8'h00);
    chk_bit(chip_in_reset, 1'b0);
    wr(ADDR_SECONDS, 8'h09);
    v = 8'h09;
    for (int i = 0; i < 3 * SECC && v === 8'h09; i++) rd(ADDR_SECONDS, v);
    chk_byte(v, 8'h10);
    wr(ADDR_MINUTES, 8'h59);
    wr(ADDR_SECONDS, 8'h59);
    repeat (3 * SECC) if (hours_carry !== 1'b1) @(posedge core_clk) #1;
    chk_bit(hours_carry, 1'b1);
    rd(ADDR_MINUTES, v); chk_byte(v, 8'h00);
    rd(ADDR_SECONDS, v); chk_byte(v, 8'h00);
  endtask : t_count

  task automatic t_stop;
    @(posedge core_clk);
    osc_running <= 1'b0;
    wait_rst(1'b1, 10); chk_bit(chip_in_reset, 1'b1);
    rd(ADDR_SECONDS, v); chk_bit(v[7], 1'b1);
    rd(ADDR_MINUTES, v); chk_byte(v, 8'h00);
    @(posedge core_clk);
    osc_running <= 1'b1;
    wait_rst(1'b0, 200);
    wr(ADDR_SECONDS, 8'h00);
    supply_low <= 1'b1;
    wait_rst(1'b1, 10); chk_bit(chip_in_reset, 1'b1);
    rd(ADDR_SECONDS, v); chk_bit(v[7], 1'b1);
    @(posedge core_clk);
    supply_low <= 1'b0;
    wait_rst(1'b0, 200); chk_bit(chip_in_reset, 1'b0);
  endtask : t_stop

  // watchdog against a hang
  initial begin
    #(50 * 20000);
    errors++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk) #1;
    t_power_on();
    t_override();
    t_osc_start();
    t_count();
    t_stop();
    conclude();
  end
endmodule : test_rtcsm_core
